// ==== rtl/abx_ahb_slave.sv ====
// AHB-Lite slave front end: zero wait states, always OKAY.
// Assumes the core answers reads combinationally from the address phase.
`timescale 1ns/10ps
module abx_ahb_slave
  import abx_pkg::*;
(
  input  logic              hclk,
  input  logic              hresetn,
  input  logic              hsel,
  input  logic [31:0]       haddr,
  input  logic [1:0]        htrans,
  input  logic              hwrite,
  input  logic [2:0]        hsize,
  input  logic [31:0]       hwdata,
  input  logic              hready,
  output logic [31:0]       hrdata,
  output logic              hreadyout,
  output logic              hresp,
  abx_regbus_if.front       bus
);

  typedef struct packed {
    logic        wpend;
    logic [31:0] waddr;
    logic [31:0] rdata;
    logic        rdy;
    logic        resp;
  } abx_ahb_state_t;

  abx_ahb_state_t st;
  abx_ahb_state_t nx;
  logic           take;

  assign take = hsel & hready & htrans[1];

  always_comb
  begin
    nx       = st;
    nx.rdy   = 1'b1;
    nx.resp  = 1'b0;
    // Sub-word writes are dropped rather than merged
    nx.wpend = take & hwrite & (hsize == SIZE_WORD);
    if (take)
      nx.waddr = haddr;
    if (take & ~hwrite)
      nx.rdata = bus.rd_data;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st <= '{wpend: 1'b0, waddr: 32'h0000_0000, rdata: 32'h0000_0000, rdy: 1'b1, resp: 1'b0};
    else
      st <= nx;
  end

  assign bus.rd_addr = haddr;
  assign bus.wr_en   = st.wpend;
  assign bus.wr_addr = st.waddr;
  assign bus.wr_data = hwdata;
  assign hrdata      = st.rdata;
  assign hreadyout   = st.rdy;
  assign hresp       = st.resp;

endmodule : abx_ahb_slave

// ==== rtl/abx_execute.sv ====
// Execute core: 32 working registers, flags, ALU, multiplier, branch unit.
// Assumes software loads operands over AHB-Lite, then writes a command.
//
// Overview of operation
// - add registers, optional carry, six flags, one cycle
// - word add immediate to pair, two cycles
// - subtract register or constant, optional carry
// - word subtract immediate from pair, two cycles
// - and, or, xor set zero, negative, overflow
// - set or clear bits by mask
// - test register, flags only, value kept
// - integer multiplies into R1:R0, two cycles
// - fractional multiplies shift product left once
// - pointer jump loads pc from Z, two
// - pointer call loads pc from Z, three
// - compares set flags without storing result
// - compare and skip when registers equal
// - skip on working register bit state
// - skip on I/O register bit state
// - branch on chosen flag set or clear
// - signed greater-or-equal branch when N^V zero
// - signed less-than branch when N^V one
// - unsigned branches on carry clear or set
`timescale 1ns/10ps
module abx_execute
  import abx_pkg::*;
(
  input  logic        hclk,
  input  logic        hresetn,
  input  logic        hsel,
  input  logic [31:0] haddr,
  input  logic [1:0]  htrans,
  input  logic        hwrite,
  input  logic [2:0]  hsize,
  input  logic [31:0] hwdata,
  input  logic        hready,
  output logic [31:0] hrdata,
  output logic        hreadyout,
  output logic        hresp
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [31:0][7:0] gpr;
    logic [7:0]       flags;
    logic [15:0]      pc;
    logic [15:0]      ret;
    logic [7:0]       ioval;
    logic [5:0]       op;
    logic [4:0]       rd;
    logic [4:0]       rr;
    logic [7:0]       imm;
    logic [2:0]       bsel;
    logic             nlong;
    logic [15:0]      ofs;
    abx_phase_t       phase;
    logic [1:0]       cnt;
    logic [2:0]       last;
    logic             bad;
  } abx_core_state_t;

  abx_core_state_t    st, nx;
  abx_regbus_if       bus ();

  logic [7:0]         vd, vr, a, b, r, f, res;
  logic [4:0]         wlo;
  logic [15:0]        word, zptr, pc1, pcrel, pcskip, w, mres, npc, nret;
  logic [2:0]         skipcyc, cyc;
  logic [8:0]         s9, ma, mb;
  logic signed [17:0] prod;
  logic               cin, is_sub, zchain, hf, vf, zf, wsub, wv, wc, frac;
  logic               znew, vnew, upd, wr8, wrw, wrm, skip, jump, bad_op, hi_ok;

  abx_ahb_slave abx_ahb_slave_i (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .bus       (bus.front)
  );

  // ************************************************************
  // Operands and adders
  // ************************************************************
  assign vd      = st.gpr[st.rd];
  assign vr      = st.gpr[st.rr];
  assign wlo     = st.rd & 5'h1E;
  assign word    = {st.gpr[wlo | 5'h01], st.gpr[wlo]};
  assign zptr    = {st.gpr[ZPTR_HI], st.gpr[ZPTR_LO]};
  assign pc1     = st.pc + 16'h0001;
  assign pcrel   = st.pc + st.ofs + 16'h0001;
  // Skip length depends on whether the next instruction is two words
  assign pcskip  = st.pc + (st.nlong ? 16'h0003 : 16'h0002);
  assign skipcyc = st.nlong ? CYC_THREE : CYC_TWO;

  assign is_sub = !(st.op inside {add_op, add_carry_op, increment_op});
  assign cin    = (st.op inside {add_carry_op, sub_carry_op, sub_const_with_carry_op,
                                 compare_carry_op}) & st.flags[FLG_C];
  assign zchain = st.op inside {sub_carry_op, sub_const_with_carry_op, compare_carry_op};
  assign a      = (st.op == twos_complement_op) ? 8'h00 : vd;
  assign b      = (st.op inside {increment_op, decrement_op}) ? 8'h01 :
                  (st.op inside {sub_const_op, sub_const_with_carry_op,
                                 compare_immediate_op}) ? st.imm :
                  (st.op == twos_complement_op) ? vd : vr;
  assign s9     = is_sub ? ({1'b0, a} - {1'b0, b} - {8'h00, cin})
                         : ({1'b0, a} + {1'b0, b} + {8'h00, cin});
  assign r      = s9[7:0];
  assign hf     = is_sub ? ((~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]))
                         : ((a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]));
  assign vf     = is_sub ? ((a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]))
                         : ((a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]));
  // Carry-chained subtracts keep zero only if it was already set
  assign zf     = (r == 8'h00) & (~zchain | st.flags[FLG_Z]);

  assign wsub = (st.op == word_sub_immediate_op);
  assign w    = wsub ? (word - {10'h000, st.imm[5:0]}) : (word + {10'h000, st.imm[5:0]});
  assign wv   = wsub ? (word[15] & ~w[15]) : (~word[15] & w[15]);
  assign wc   = wsub ? (w[15] & ~word[15]) : (~w[15] & word[15]);

  // 9x9 signed product covers all three signedness variants
  assign ma   = {(st.op inside {signed_multiply_op, signed_unsigned_multiply_op,
                                fractional_signed_multiply_op,
                                fractional_mixed_multiply_op}) & vd[7], vd};
  assign mb   = {(st.op inside {signed_multiply_op,
                                fractional_signed_multiply_op}) & vr[7], vr};
  assign prod = $signed(ma) * $signed(mb);
  assign frac = st.op inside {fractional_unsigned_multiply_op, fractional_signed_multiply_op,
                              fractional_mixed_multiply_op};
  assign mres = frac ? {prod[14:0], 1'b0} : prod[15:0];

  // ************************************************************
  // Command decode
  // ************************************************************
  always_comb
  begin
    f      = st.flags;
    res    = r;
    znew   = zf;
    vnew   = vf;
    upd    = 1'b0;
    wr8    = 1'b0;
    wrw    = 1'b0;
    wrm    = 1'b0;
    skip   = 1'b0;
    jump   = 1'b0;
    cyc    = CYC_ONE;
    npc    = pc1;
    nret   = st.ret;
    bad_op = 1'b0;
    unique case (st.op)
      add_op, add_carry_op, sub_op, sub_const_op, sub_carry_op,
      sub_const_with_carry_op, twos_complement_op:
      begin
        {upd, wr8} = 2'h3;
        f[FLG_C]   = s9[8];
        f[FLG_H]   = hf;
      end
      compare_op, compare_carry_op, compare_immediate_op:
      begin
        upd      = 1'b1;
        f[FLG_C] = s9[8];
        f[FLG_H] = hf;
      end
      increment_op, decrement_op:
        {upd, wr8} = 2'h3;
      word_add_immediate_op, word_sub_immediate_op:
      begin
        wrw      = 1'b1;
        cyc      = CYC_TWO;
        f[FLG_Z] = (w == 16'h0000);
        f[FLG_N] = w[15];
        f[FLG_V] = wv;
        f[FLG_C] = wc;
        f[FLG_S] = w[15] ^ wv;
      end
      and_op, and_const_op, or_op, or_const_op, exclusive_or_op,
      set_bits_mask_op, clear_bits_mask_op, clear_reg_op, test_zero_minus_op:
      begin
        unique case (st.op)
          and_op:             res = vd & vr;
          and_const_op:       res = vd & st.imm;
          or_op:              res = vd | vr;
          or_const_op:        res = vd | st.imm;
          exclusive_or_op:    res = vd ^ vr;
          set_bits_mask_op:   res = vd | st.imm;
          clear_bits_mask_op: res = vd & ~st.imm;
          clear_reg_op:       res = 8'h00;
          default:            res = vd;
        endcase
        upd  = 1'b1;
        wr8  = (st.op != test_zero_minus_op);
        znew = (res == 8'h00);
        vnew = 1'b0;
      end
      ones_complement_op:
      begin
        {upd, wr8} = 2'h3;
        res        = ~vd;
        znew       = (vd == 8'hFF);
        vnew       = 1'b0;
        f[FLG_C]   = 1'b1;
      end
      set_reg_op:
        {wr8, res} = {1'b1, 8'hFF};
      unsigned_multiply_op, signed_multiply_op, signed_unsigned_multiply_op,
      fractional_unsigned_multiply_op, fractional_signed_multiply_op,
      fractional_mixed_multiply_op:
      begin
        wrm      = 1'b1;
        cyc      = CYC_TWO;
        f[FLG_C] = prod[15];
        f[FLG_Z] = (mres == 16'h0000);
      end
      relative_jump_op:
        {npc, cyc} = {pcrel, CYC_TWO};
      pointer_jump_op:
        {npc, cyc} = {zptr, CYC_TWO};
      direct_jump_op:
        {npc, cyc} = {st.ofs, CYC_THREE};
      relative_call_op:
        {npc, nret, cyc} = {pcrel, pc1, CYC_THREE};
      pointer_call_op:
        {npc, nret, cyc} = {zptr, pc1, CYC_THREE};
      direct_call_op:
        {npc, nret, cyc} = {st.ofs, st.pc + 16'h0002, CYC_FOUR};
      return_op:
        {npc, cyc} = {st.ret, CYC_FOUR};
      return_irq_op:
        {npc, cyc, f[FLG_I]} = {st.ret, CYC_FOUR, 1'b1};
      compare_skip_equal_op:  skip = (vd == vr);
      skip_reg_bit_clear_op:  skip = ~vr[st.bsel];
      skip_reg_bit_set_op:    skip = vr[st.bsel];
      skip_io_bit_clear_op:   skip = ~st.ioval[st.bsel];
      skip_io_bit_set_op:     skip = st.ioval[st.bsel];
      branch_flag_set_op:     jump = st.flags[st.bsel];
      branch_flag_clear_op:   jump = ~st.flags[st.bsel];
      branch_signed_ge_op:    jump = ~(st.flags[FLG_N] ^ st.flags[FLG_V]);
      branch_signed_lt_op:    jump = st.flags[FLG_N] ^ st.flags[FLG_V];
      branch_unsigned_ge_op:  jump = ~st.flags[FLG_C];
      branch_unsigned_lt_op:  jump = st.flags[FLG_C];
      // Unknown codes retire as a one-cycle no-op and raise the error bit
      default:                bad_op = 1'b1;
    endcase
    if (upd)
      {f[FLG_S], f[FLG_V], f[FLG_N], f[FLG_Z]} = {res[7] ^ vnew, vnew, res[7], znew};
    if (skip)
      {npc, cyc} = {pcskip, skipcyc};
    if (jump)
      {npc, cyc} = {pcrel, CYC_TWO};
  end

  // ************************************************************
  // Register writes and sequencing
  // ************************************************************
  assign hi_ok = (bus.wr_addr[31:8] == 24'h000000);

  always_comb
  begin
    nx = st;
    if (bus.wr_en && hi_ok && bus.wr_addr[7:0] == ADDR_STATUS && bus.wr_data[STAT_BAD_BIT])
      nx.bad = 1'b0;
    // Writes other than the status clear are dropped while a command runs
    if (bus.wr_en && hi_ok && st.phase == ABX_IDLE)
    begin
      if (bus.wr_addr[7] && bus.wr_addr[1:0] == 2'h0)
        nx.gpr[bus.wr_addr[6:2]] = bus.wr_data[7:0];
      unique case (bus.wr_addr[7:0])
        ADDR_CMD:
        begin
          nx.op    = bus.wr_data[5:0];
          nx.rd    = bus.wr_data[CMD_RD_LSB +: 5];
          nx.rr    = bus.wr_data[CMD_RR_LSB +: 5];
          nx.phase = ABX_EXEC;
          nx.cnt   = 2'h0;
        end
        ADDR_ARG:
        begin
          nx.imm   = bus.wr_data[7:0];
          nx.bsel  = bus.wr_data[ARG_BSEL_LSB +: 3];
          nx.nlong = bus.wr_data[ARG_LONG_BIT];
          nx.ofs   = bus.wr_data[ARG_OFS_LSB +: 16];
        end
        ADDR_FLAGS: nx.flags = bus.wr_data[7:0];
        ADDR_PC:    nx.pc    = bus.wr_data[15:0];
        ADDR_RET:   nx.ret   = bus.wr_data[15:0];
        ADDR_IOVAL: nx.ioval = bus.wr_data[7:0];
        default:    ;
      endcase
    end
    unique case (st.phase)
      ABX_IDLE: ;
      ABX_EXEC:
        if ({1'b0, st.cnt} == cyc - CYC_ONE)
        begin
          nx.phase = ABX_IDLE;
          nx.pc    = npc;
          nx.ret   = nret;
          nx.flags = f;
          nx.last  = cyc;
          nx.bad   = nx.bad | bad_op; // Same-cycle clear kept, new set wins
          if (wr8)
            nx.gpr[st.rd] = res;
          if (wrw)
          begin
            nx.gpr[wlo]         = w[7:0];
            nx.gpr[wlo | 5'h01] = w[15:8];
          end
          if (wrm)
          begin
            nx.gpr[0] = mres[7:0];
            nx.gpr[1] = mres[15:8];
          end
        end
        else
          nx.cnt = st.cnt + 2'h1;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st       <= '0;
      st.pc    <= PC_RESET;
      st.flags <= FLAGS_RESET;
      st.phase <= ABX_IDLE;
    end
    else
      st <= nx;
  end

  // ************************************************************
  // Read mux
  // ************************************************************
  always_comb
  begin
    bus.rd_data = 32'h0000_0000;
    if (bus.rd_addr[31:8] == 24'h000000)
    begin
      if (bus.rd_addr[7] && bus.rd_addr[1:0] == 2'h0)
        bus.rd_data = {24'h000000, st.gpr[bus.rd_addr[6:2]]};
      unique case (bus.rd_addr[7:0])
        ADDR_CMD:    bus.rd_data = {11'h000, st.rr, 3'h0, st.rd, 2'h0, st.op};
        ADDR_ARG:    bus.rd_data = {st.ofs, 4'h0, st.nlong, st.bsel, st.imm};
        ADDR_FLAGS:  bus.rd_data = {24'h000000, st.flags};
        ADDR_PC:     bus.rd_data = {16'h0000, st.pc};
        ADDR_RET:    bus.rd_data = {16'h0000, st.ret};
        ADDR_IOVAL:  bus.rd_data = {24'h000000, st.ioval};
        ADDR_STATUS: bus.rd_data = {27'h0000000, st.last, st.bad, st.phase == ABX_EXEC};
        default:     ;
      endcase
    end
  end

endmodule : abx_execute

// ==== rtl/abx_pkg.sv ====
// Constants shared by the execute block: register map, flag bits, command codes.
// Assumes a 32-bit AHB-Lite bus with word-only transfers.
package abx_pkg;

  // ************************************************************
  // Register map (byte offsets, high address bits must be zero)
  // ************************************************************
  localparam logic [7:0] ADDR_CMD    = 8'h00;
  localparam logic [7:0] ADDR_ARG    = 8'h04;
  localparam logic [7:0] ADDR_FLAGS  = 8'h08;
  localparam logic [7:0] ADDR_PC     = 8'h0C;
  localparam logic [7:0] ADDR_RET    = 8'h10;
  localparam logic [7:0] ADDR_IOVAL  = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [2:0] SIZE_WORD   = 3'h2;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CMD_RD_LSB   = 8;
  localparam int CMD_RR_LSB   = 16;
  localparam int ARG_BSEL_LSB = 8;
  localparam int ARG_LONG_BIT = 11;
  localparam int ARG_OFS_LSB  = 16;
  localparam int STAT_BAD_BIT = 1;
  localparam int FLG_C = 0, FLG_Z = 1, FLG_N = 2, FLG_V = 3;
  localparam int FLG_S = 4, FLG_H = 5, FLG_I = 7;
  localparam logic [4:0] ZPTR_LO = 5'h1E, ZPTR_HI = 5'h1F;

  // ************************************************************
  // Reset values and cycle counts
  // ************************************************************
  localparam logic [15:0] PC_RESET    = 16'h0000;
  localparam logic [7:0]  FLAGS_RESET = 8'h00;
  localparam logic [2:0]  CYC_ONE = 3'h1, CYC_TWO = 3'h2;
  localparam logic [2:0]  CYC_THREE = 3'h3, CYC_FOUR = 3'h4;

  // ************************************************************
  // Command codes
  // ************************************************************
  localparam logic [5:0] add_op = 6'h00, add_carry_op = 6'h01, word_add_immediate_op = 6'h02,
    sub_op = 6'h03, sub_const_op = 6'h04, sub_carry_op = 6'h05,
    sub_const_with_carry_op = 6'h06, word_sub_immediate_op = 6'h07,
    and_op = 6'h08, and_const_op = 6'h09, or_op = 6'h0A, or_const_op = 6'h0B,
    exclusive_or_op = 6'h0C, ones_complement_op = 6'h0D, twos_complement_op = 6'h0E,
    set_bits_mask_op = 6'h0F, clear_bits_mask_op = 6'h10, increment_op = 6'h11,
    decrement_op = 6'h12, test_zero_minus_op = 6'h13, clear_reg_op = 6'h14,
    set_reg_op = 6'h15, unsigned_multiply_op = 6'h16, signed_multiply_op = 6'h17,
    signed_unsigned_multiply_op = 6'h18, fractional_unsigned_multiply_op = 6'h19,
    fractional_signed_multiply_op = 6'h1A, fractional_mixed_multiply_op = 6'h1B,
    relative_jump_op = 6'h20, pointer_jump_op = 6'h21, direct_jump_op = 6'h22,
    relative_call_op = 6'h23, pointer_call_op = 6'h24, direct_call_op = 6'h25,
    return_op = 6'h26, return_irq_op = 6'h27, compare_skip_equal_op = 6'h28,
    compare_op = 6'h29, compare_carry_op = 6'h2A, compare_immediate_op = 6'h2B,
    skip_reg_bit_clear_op = 6'h2C, skip_reg_bit_set_op = 6'h2D,
    skip_io_bit_clear_op = 6'h2E, skip_io_bit_set_op = 6'h2F,
    branch_flag_set_op = 6'h30, branch_flag_clear_op = 6'h31,
    branch_signed_ge_op = 6'h32, branch_signed_lt_op = 6'h33,
    branch_unsigned_ge_op = 6'h34, branch_unsigned_lt_op = 6'h35;

  typedef enum logic {ABX_IDLE, ABX_EXEC} abx_phase_t;

endpackage : abx_pkg

// ==== rtl/abx_regbus_if.sv ====
// Register access path between the bus front end and the execute core.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface abx_regbus_if;
  logic        wr_en;
  logic [31:0] wr_addr;
  logic [31:0] wr_data;
  logic [31:0] rd_addr;
  logic [31:0] rd_data;
  modport front (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
  modport core  (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface : abx_regbus_if

// ==== test/abx_execute_sva.sv ====
// Bus-side checker for the execute block.
// Assumes one AHB-Lite master with hready fed back from hreadyout.
`timescale 1ns/10ps
module abx_execute_sva
  import abx_pkg::*;
(
  input logic        hclk,
  input logic        hresetn,
  input logic        hsel,
  input logic [31:0] haddr,
  input logic [1:0]  htrans,
  input logic        hwrite,
  input logic [2:0]  hsize,
  input logic [31:0] hwdata,
  input logic        hready,
  input logic [31:0] hrdata,
  input logic        hreadyout,
  input logic        hresp
);
  // ************************************************************
  // Read decode and assertions
  // ************************************************************
  logic rd_acc;
  logic hi0;
  assign rd_acc = hsel && hready && htrans[1] && !hwrite;
  assign hi0    = haddr[31:8] == 24'h0;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_ready; $rose(hresetn) |-> hreadyout [*2]; endproperty
  a_ready: assert property (p_ready) else $error("wait state after reset");
  property p_okay; !hresp && hreadyout; endproperty
  a_okay: assert property (p_okay) else $error("response not OKAY");
  property p_unmap; rd_acc && !hi0 |=> hrdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_hold; !rd_acc |=> $stable(hrdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_reg; rd_acc && hi0 && haddr[7] |=> hrdata[31:8] == 24'h0; endproperty
  a_reg: assert property (p_reg) else $error("register wider than byte");
  property p_stat;
    rd_acc && hi0 && haddr[7:0] == ADDR_STATUS |=> hrdata[31:5] == 27'h0 && hrdata[4:2] <= 3'h4;
  endproperty
  a_stat: assert property (p_stat) else $error("cycle count out of range");
  property p_pc; rd_acc && hi0 && haddr[7:0] == ADDR_PC |=> hrdata[31:16] == 16'h0; endproperty
  a_pc: assert property (p_pc) else $error("pc wider than 16 bits");
  property p_flg; rd_acc && hi0 && haddr[7:0] == ADDR_FLAGS |=> hrdata[31:8] == 24'h0; endproperty
  a_flg: assert property (p_flg) else $error("flags wider than byte");
  c_st: cover property (rd_acc && hi0 && haddr[7:0] == ADDR_STATUS);
  c_cmd: cover property (hsel && htrans[1] && hwrite && hi0 && haddr[7:0] == ADDR_CMD);
  c_unm: cover property (rd_acc && !hi0);
endmodule : abx_execute_sva

bind abx_execute abx_execute_sva abx_execute_sva_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

// ==== test/abx_execute_tb.sv ====
// Self-checking bench for the execute block.
// Assumes a zero-wait slave; the bench is the only bus master.
`timescale 1ns/10ps
module abx_execute_tb
  import abx_pkg::*;
;
  logic        hclk, hreadyout, hresp;
  logic        hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = SIZE_WORD;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  int          n_errors = 0, n_tests = 0;
  localparam logic [8:0] a_arg = {1'b0, ADDR_ARG}, a_cmd = {1'b0, ADDR_CMD};
  localparam logic [8:0] a_flg = {1'b0, ADDR_FLAGS}, a_pc = {1'b0, ADDR_PC};
  localparam logic [8:0] a_ret = {1'b0, ADDR_RET}, a_st = {1'b0, ADDR_STATUS};
  localparam logic [8:0] a_io = {1'b0, ADDR_IOVAL};
  abx_execute abx_execute_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  // ************************************************************
  // Bus and check helpers
  // ************************************************************
  task print_verdict;
    if (n_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  task chk(input logic [31:0] s, e);
    n_tests++;
    if (s !== e)
    begin
      n_errors++;
      $display("BAD %0t %h %h", $time, s, e);
    end
  endtask : chk
  task rdy;
    for (int n = 0; n < 50; n++)
    begin
      @(posedge hclk);
      if (hreadyout === 1'b1)
        return;
    end
    n_errors++;
    print_verdict();
  endtask : rdy
  task xfer(input logic [8:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {23'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    q = hrdata;
  endtask : xfer
  task rc(input logic [8:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk(q, e);
  endtask : rc
  function automatic logic [8:0] rg(input int n);
    return 9'(128 + 4 * n);
  endfunction : rg
  // Polls busy; status word also carries bad-op bit and cycle count
  task cmd(input logic [5:0] op, input int d, r, input logic [31:0] arg, e);
    xfer(a_arg, 1'b1, arg);
    xfer(a_cmd, 1'b1, {11'h0, 5'(r), 3'h0, 5'(d), 2'h0, op});
    for (int n = 0; n < 20; n++)
    begin
      xfer(a_st, 1'b0, 32'h0);
      if (q[0] === 1'b0)
        break;
    end
    chk(q, e);
    if (q[0] !== 1'b0)
      print_verdict();
  endtask : cmd
  // ************************************************************
  // Scenarios: flags chain from one to the next
  // ************************************************************
  task s_arith;
    xfer(rg(3), 1'b1, 32'h7F);
    xfer(rg(4), 1'b1, 32'h01);
    xfer(a_flg, 1'b1, 32'h0);
    cmd(add_op, 3, 4, 32'h0, 32'h4);
    rc(rg(3), 32'h80);
    rc(a_flg, 32'h2C);
    xfer(rg(26), 1'b1, 32'h0);
    xfer(rg(27), 1'b1, 32'h0);
    cmd(word_sub_immediate_op, 26, 0, 32'h1, 32'h8);
    rc(rg(27), 32'hFF);
    rc(a_flg, 32'h35);
  endtask : s_arith
  task s_mul;
    xfer(rg(16), 1'b1, 32'h80);
    xfer(rg(17), 1'b1, 32'h80);
    cmd(fractional_signed_multiply_op, 16, 17, 32'h0, 32'h8);
    rc(rg(0), 32'h00);
    rc(rg(1), 32'h80);
    rc(a_flg, 32'h34);
  endtask : s_mul
  task s_flow;
    xfer(a_pc, 1'b1, 32'h10);
    xfer(rg(30), 1'b1, 32'h34);
    xfer(rg(31), 1'b1, 32'h12);
    cmd(pointer_call_op, 0, 0, 32'h0, 32'hC);
    rc(a_pc, 32'h1234);
    rc(a_ret, 32'h0011);
    cmd(branch_signed_lt_op, 0, 0, 32'h0005_0000, 32'h8);
    rc(a_pc, 32'h123A);
    cmd(compare_skip_equal_op, 3, 1, 32'h800, 32'hC);
    rc(a_pc, 32'h123D);
  endtask : s_flow
  task s_logic;
    cmd(and_const_op, 3, 0, 32'h0F, 32'h4);
    rc(rg(3), 32'h00);
    rc(a_flg, 32'h22);
    cmd(set_bits_mask_op, 3, 0, 32'hA0, 32'h4);
    rc(rg(3), 32'hA0);
    rc(a_flg, 32'h34);
    cmd(test_zero_minus_op, 4, 0, 32'h0, 32'h4);
    rc(a_flg, 32'h20);
    cmd(compare_immediate_op, 4, 0, 32'h02, 32'h4);
    rc(rg(4), 32'h01);
    rc(a_flg, 32'h35);
    xfer(a_flg, 1'b1, 32'h0);
    cmd(ones_complement_op, 4, 0, 32'h0, 32'h4);
    rc(rg(4), 32'hFE);
    rc(a_flg, 32'h15);
    cmd(unsigned_multiply_op, 16, 17, 32'h0, 32'h8);
    rc(rg(1), 32'h40);
    rc(a_flg, 32'h14);
    cmd(word_add_immediate_op, 26, 0, 32'h1, 32'h8);
    rc(rg(27), 32'h00);
    rc(a_flg, 32'h03);
  endtask : s_logic
  task s_branch;
    xfer(a_pc, 1'b1, 32'h100);
    cmd(branch_unsigned_ge_op, 0, 0, 32'h0010_0000, 32'h4);
    rc(a_pc, 32'h101);
    cmd(branch_unsigned_lt_op, 0, 0, 32'h0010_0000, 32'h8);
    rc(a_pc, 32'h112);
    cmd(branch_flag_clear_op, 0, 0, 32'h0003_0300, 32'h8);
    rc(a_pc, 32'h116);
    cmd(branch_signed_ge_op, 0, 0, 32'hFFFE_0000, 32'h8);
    rc(a_pc, 32'h115);
    cmd(skip_reg_bit_clear_op, 0, 4, 32'h0, 32'h8);
    rc(a_pc, 32'h117);
    xfer(a_io, 1'b1, 32'h80);
    cmd(skip_io_bit_set_op, 0, 0, 32'h0F00, 32'hC);
    rc(a_pc, 32'h11A);
    cmd(pointer_jump_op, 0, 0, 32'h0, 32'h8);
    rc(a_pc, 32'h1234);
    // Unknown code sets the sticky error bit; writing one clears it
    cmd(6'h3F, 0, 0, 32'h0, 32'h6);
    xfer(a_st, 1'b1, 32'h2);
    rc(a_st, 32'h4);
  endtask : s_branch
  initial
  begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc(a_pc, 32'h0);
    rc(9'h100, 32'h0);
    s_arith();
    s_mul();
    s_flow();
    s_logic();
    s_branch();
    print_verdict();
  end
endmodule : abx_execute_tb
